/* File: pkg/asf_pkg.sv */
// constants for the converter status flag block: register map, fields, resets
// assumes a 32-bit classic wishbone slave and a same-clock conversion core
// Functional notes
// - only last-result read clears data-ready
// - last-result read plus disabled-channel end clears data-ready
// - enabled-channel end sets data-ready despite other reads
// - disable plus other end: store both, raise data-ready
// - status read still updates general overrun
// - channel read at end with flags sets overrun
// - disable at end with flags: both overruns rise
// - channel or last-result read clears channel end flag
// - status read clears channel overrun, even during end, unless that end sets it
// - disabled channel never raises its end flag
// - channel read clears only its own end flag
// - sleep takes effect after next conversion completes
package asf_pkg;
	localparam int ASF_CHANS = 8;
	localparam int ASF_DW = 10;
	localparam int ASF_CHW = 3;
	// byte offsets
	localparam logic [7:0] ASF_OFF_CTRL = 8'h00;
	localparam logic [7:0] ASF_OFF_MODE = 8'h04;
	localparam logic [7:0] ASF_OFF_CHEN = 8'h10;
	localparam logic [7:0] ASF_OFF_CHDIS = 8'h14;
	localparam logic [7:0] ASF_OFF_CHSR = 8'h18;
	localparam logic [7:0] ASF_OFF_SR = 8'h1c;
	localparam logic [7:0] ASF_OFF_LAST_CONVERTED_DATA_REG = 8'h20;
	localparam logic [7:0] ASF_OFF_IER = 8'h24;
	localparam logic [7:0] ASF_OFF_ICR = 8'h28;
	localparam logic [7:0] ASF_OFF_ISR = 8'h2c;
	localparam logic [7:0] ASF_OFF_CDR0 = 8'h30;
	// field positions
	localparam int ASF_CTRL_START = 0;
	localparam int ASF_MODE_SLEEP = 0;
	localparam int ASF_SR_CHANNEL_OVERRUN_FLAG_LSB = 8;
	localparam int ASF_SR_DATA_READY_FLAG = 16;
	localparam int ASF_SR_GENERAL_OVERRUN_FLAG = 17;
	localparam int ASF_LAST_CONVERTED_DATA_REG_CH_LSB = 16;
	localparam int ASF_IRQ_DATA_READY_FLAG = 0;
	localparam int ASF_IRQ_GENERAL_OVERRUN_FLAG = 1;
	localparam int ASF_IRQ_CHANNEL_OVERRUN_FLAG = 2;
	localparam int ASF_IRQ_W = 3;
	// reset values
	localparam logic [7:0] ASF_CHEN_RST = 8'h00;
	localparam logic [2:0] ASF_IER_RST = 3'h0;
	localparam logic ASF_SLEEP_RST = 1'h0;
endpackage

/* File: logic/asf_chan_cell.sv */
// one channel's data register, end-of-conversion flag and overrun flag
// assumes the top decides store, clear and overrun conditions
`timescale 1ns/100ps
module asf_chan_cell import asf_pkg::*; #(
	parameter int DW = ASF_DW
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// controls from the flag logic
	input wire logic store_i,
	input wire logic [DW-1:0] data_i,
	input wire logic clr_eoc_i,
	input wire logic ovr_set_i,
	input wire logic stat_rd_i,
	// state
	output logic eoc_o,
	output logic channel_overrun_flag_o,
	output logic [DW-1:0] data_o
);
	typedef struct packed {
		logic eoc;
		logic channel_overrun_flag;
		logic [DW-1:0] data;
	} asf_cell_t;
	asf_cell_t s;
	asf_cell_t next_s;

	always_comb begin
		next_s = s;
		if (store_i) begin
			next_s.data = data_i;
		end
		// a new end wins over a read clear in the same cycle
		if (store_i) begin
			next_s.eoc = 1'b1;
		end else if (clr_eoc_i) begin
			next_s.eoc = 1'b0;
		end
		if (ovr_set_i) begin
			next_s.channel_overrun_flag = 1'b1;
		end else if (stat_rd_i) begin
			next_s.channel_overrun_flag = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign eoc_o = s.eoc;
	assign channel_overrun_flag_o = s.channel_overrun_flag;
	assign data_o = s.data;
endmodule

/* File: logic/asf_status_top.sv */
// converter status flag logic with a classic wishbone register slave
// assumes the conversion core runs on clk_i and pulses conv_done_i once per result
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module asf_status_top import asf_pkg::*; #(
	parameter int NCH = ASF_CHANS,
	parameter int DW = ASF_DW
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	// conversion core
	input wire logic conv_done_i,
	input wire logic [ASF_CHW-1:0] conv_chan_i,
	input wire logic [DW-1:0] conv_data_i,
	output logic start_o,
	output logic sleep_o,
	output logic [NCH-1:0] chan_en_o,
	// interrupt
	output logic irq_o
);
	generate
		if (NCH < 1 || NCH > 8 || DW < 1 || DW > 16) begin : g_bad
			$error("asf_status_top: NCH must be 1..8 and DW 1..16");
		end
	endgenerate

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic start;
		logic sleep_req;
		logic sleep_on;
		logic [NCH-1:0] en;
		logic data_ready_flag;
		logic general_overrun_flag;
		logic [ASF_CHW-1:0] last_ch;
		logic [DW-1:0] last_data;
		logic [ASF_IRQ_W-1:0] ier;
		logic [ASF_IRQ_W-1:0] isr;
		logic irq;
	} asf_state_t;

	asf_state_t s;
	asf_state_t next_s;

	// true when the address falls on a channel data register
	function automatic logic cdr_hit(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - ASF_OFF_CDR0;
		return (a >= ASF_OFF_CDR0) && (rel[1:0] == 2'h0) && (rel[7:2] < 6'(NCH));
	endfunction

	function automatic logic [2:0] cdr_idx(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - ASF_OFF_CDR0;
		return rel[4:2];
	endfunction

	logic req;
	logic rd;
	logic wr;
	logic last_converted_data_reg_rd;
	logic sr_rd;
	logic cdr_rd;
	logic store;
	logic [NCH-1:0] dis_mask;
	logic [NCH-1:0] store_vec;
	logic [NCH-1:0] clr_eoc;
	logic [NCH-1:0] ovr_set;
	logic [NCH-1:0] eoc_vec;
	logic [NCH-1:0] channel_overrun_flag_vec;
	logic [DW-1:0] cdr_data [NCH];
	logic [31:0] rdat;
	logic [ASF_IRQ_W-1:0] ev;

	// requests are taken in the cycle before ack, so read data and side effects agree
	assign req = cyc_i && stb_i && !s.ack;
	assign rd = req && !we_i;
	assign wr = req && we_i && sel_i[0];
	assign last_converted_data_reg_rd = rd && adr_i == ASF_OFF_LAST_CONVERTED_DATA_REG;
	assign sr_rd = rd && adr_i == ASF_OFF_SR;
	assign cdr_rd = rd && cdr_hit(adr_i);
	assign dis_mask = (wr && adr_i == ASF_OFF_CHDIS) ? dat_i[NCH-1:0] : '0;
	assign store = |store_vec;

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			// a channel disabled before or at its end stores nothing
			assign store_vec[gi] = conv_done_i && conv_chan_i == ASF_CHW'(gi)
				&& s.en[gi] && !dis_mask[gi];
			assign clr_eoc[gi] = (cdr_rd && cdr_idx(adr_i) == 3'(gi))
				|| (last_converted_data_reg_rd && s.last_ch == ASF_CHW'(gi));
			// data read in the same cycle is not counted as lost
			assign ovr_set[gi] = store_vec[gi] && eoc_vec[gi] && !clr_eoc[gi];
			asf_chan_cell #(.DW(DW)) u_cell (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.store_i(store_vec[gi]),
				.data_i(conv_data_i),
				.clr_eoc_i(clr_eoc[gi]),
				.ovr_set_i(ovr_set[gi]),
				.stat_rd_i(sr_rd),
				.eoc_o(eoc_vec[gi]),
				.channel_overrun_flag_o(channel_overrun_flag_vec[gi]),
				.data_o(cdr_data[gi])
			);
		end
	endgenerate

	// read data mux
	always_comb begin
		rdat = '0;
		case (adr_i)
			ASF_OFF_MODE: begin
				rdat[ASF_MODE_SLEEP] = s.sleep_req;
			end
			ASF_OFF_CHSR: begin
				rdat[NCH-1:0] = s.en;
			end
			ASF_OFF_SR: begin
				rdat[NCH-1:0] = eoc_vec;
				rdat[ASF_SR_CHANNEL_OVERRUN_FLAG_LSB +: NCH] = channel_overrun_flag_vec;
				rdat[ASF_SR_DATA_READY_FLAG] = s.data_ready_flag;
				rdat[ASF_SR_GENERAL_OVERRUN_FLAG] = s.general_overrun_flag;
			end
			ASF_OFF_LAST_CONVERTED_DATA_REG: begin
				rdat[DW-1:0] = s.last_data;
				rdat[ASF_LAST_CONVERTED_DATA_REG_CH_LSB +: ASF_CHW] = s.last_ch;
			end
			ASF_OFF_IER: begin
				rdat[ASF_IRQ_W-1:0] = s.ier;
			end
			ASF_OFF_ISR: begin
				rdat[ASF_IRQ_W-1:0] = s.isr;
			end
			default: begin
				if (cdr_hit(adr_i)) begin
					rdat[DW-1:0] = cdr_data[cdr_idx(adr_i)];
				end
			end
		endcase
	end

	always_comb begin
		next_s = s;
		next_s.ack = req;
		next_s.dat = rd ? rdat : s.dat;
		next_s.start = wr && adr_i == ASF_OFF_CTRL && dat_i[ASF_CTRL_START];
		if (wr && adr_i == ASF_OFF_MODE) begin
			next_s.sleep_req = dat_i[ASF_MODE_SLEEP];
		end
		if (wr && adr_i == ASF_OFF_CHEN) begin
			next_s.en = s.en | dat_i[NCH-1:0];
		end
		next_s.en = next_s.en & ~dis_mask;
		if (wr && adr_i == ASF_OFF_IER) begin
			next_s.ier = dat_i[ASF_IRQ_W-1:0];
		end
		// sleep is only entered at a conversion end; a start wakes the core
		if (!s.sleep_req || next_s.start) begin
			next_s.sleep_on = 1'b0;
		end else if (conv_done_i) begin
			next_s.sleep_on = 1'b1;
		end
		if (store) begin
			next_s.last_ch = conv_chan_i;
			next_s.last_data = conv_data_i;
		end
		// channel data reads never touch data-ready
		if (store) begin
			next_s.data_ready_flag = 1'b1;
		end else if (last_converted_data_reg_rd) begin
			next_s.data_ready_flag = 1'b0;
		end
		if (store && s.data_ready_flag && !last_converted_data_reg_rd) begin
			next_s.general_overrun_flag = 1'b1;
		end else if (sr_rd) begin
			next_s.general_overrun_flag = 1'b0;
		end
		ev = '0;
		ev[ASF_IRQ_DATA_READY_FLAG] = store;
		ev[ASF_IRQ_GENERAL_OVERRUN_FLAG] = store && s.data_ready_flag && !last_converted_data_reg_rd;
		ev[ASF_IRQ_CHANNEL_OVERRUN_FLAG] = |ovr_set;
		if (wr && adr_i == ASF_OFF_ICR) begin
			next_s.isr = s.isr & ~dat_i[ASF_IRQ_W-1:0];
		end
		next_s.isr = next_s.isr | ev;
		next_s.irq = |(next_s.isr & next_s.ier);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.en <= ASF_CHEN_RST[NCH-1:0];
			s.ier <= ASF_IER_RST;
			s.sleep_req <= ASF_SLEEP_RST;
		end else begin
			s <= next_s;
		end
	end

	assign ack_o = s.ack;
	assign dat_o = s.dat;
	assign start_o = s.start;
	assign sleep_o = s.sleep_on;
	assign chan_en_o = s.en;
	assign irq_o = s.irq;

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic data_ready_flag_q;
	assign data_ready_flag_q = s.data_ready_flag;

	property p_data_ready_flag_cdr;
		cdr_rd && !last_converted_data_reg_rd && !store |=> s.data_ready_flag == $past(data_ready_flag_q);
	endproperty
	a_data_ready_flag_cdr: assert property (p_data_ready_flag_cdr) else $error("data-ready changed on channel read");

	property p_data_ready_flag_last_converted_data_reg_dis;
		last_converted_data_reg_rd && conv_done_i && !store |=> !s.data_ready_flag;
	endproperty
	a_data_ready_flag_last_converted_data_reg_dis: assert property (p_data_ready_flag_last_converted_data_reg_dis) else $error("data-ready kept without stored data");

	property p_data_ready_flag_set;
		store |=> s.data_ready_flag ##1 (s.data_ready_flag || $past(last_converted_data_reg_rd));
	endproperty
	a_data_ready_flag_set: assert property (p_data_ready_flag_set) else $error("data-ready not set on stored result");

	property p_store_both;
		store && (|dis_mask) |=> s.data_ready_flag && s.last_data == $past(conv_data_i);
	endproperty
	a_store_both: assert property (p_store_both) else $error("result lost during channel disable");

	property p_general_overrun_flag_clr;
		sr_rd && !(store && s.data_ready_flag) |=> !s.general_overrun_flag;
	endproperty
	a_general_overrun_flag_clr: assert property (p_general_overrun_flag_clr) else $error("general overrun not cleared by status read");

	property p_general_overrun_flag_set;
		store && s.data_ready_flag && !last_converted_data_reg_rd |=> s.general_overrun_flag;
	endproperty
	a_general_overrun_flag_set: assert property (p_general_overrun_flag_set) else $error("general overrun not set");

	property p_channel_overrun_flag_set;
		|ovr_set && s.data_ready_flag && !last_converted_data_reg_rd |=> (channel_overrun_flag_vec & $past(ovr_set)) == $past(ovr_set) && s.general_overrun_flag;
	endproperty
	a_channel_overrun_flag_set: assert property (p_channel_overrun_flag_set) else $error("overrun flags not both raised");

	property p_eoc_clr;
		|(clr_eoc & ~store_vec) |=> (eoc_vec & $past(clr_eoc) & ~$past(store_vec)) == '0;
	endproperty
	a_eoc_clr: assert property (p_eoc_clr) else $error("end flag not cleared by read");

	property p_channel_overrun_flag_clr;
		sr_rd && !(|ovr_set) |=> channel_overrun_flag_vec == '0;
	endproperty
	a_channel_overrun_flag_clr: assert property (p_channel_overrun_flag_clr) else $error("channel overrun survived status read");

	property p_eoc_rise;
		1'b1 |=> (eoc_vec & ~$past(eoc_vec) & ~$past(store_vec)) == '0;
	endproperty
	a_eoc_rise: assert property (p_eoc_rise) else $error("end flag rose without stored result");

	property p_eoc_keep;
		1'b1 |=> ($past(eoc_vec) & ~$past(clr_eoc) & ~eoc_vec) == '0;
	endproperty
	a_eoc_keep: assert property (p_eoc_keep) else $error("end flag of another channel cleared");

	property p_sleep;
		s.sleep_req && !conv_done_i && !s.sleep_on |=> !s.sleep_on;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entered without conversion end");

	property p_sleep_enter;
		s.sleep_req && conv_done_i && !next_s.start && !wr |=> s.sleep_on ##1 (s.sleep_on || !s.sleep_req || s.start);
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered at conversion end");

	property p_store_data;
		store |=> s.last_ch == $past(conv_chan_i) && eoc_vec[s.last_ch];
	endproperty
	a_store_data: assert property (p_store_data) else $error("stored result not flagged");

	property p_ack;
		req |=> s.ack ##1 !s.ack;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer not one cycle");

	c_overrun: cover property (|ovr_set);
	c_last_converted_data_reg_end: cover property (last_converted_data_reg_rd && store);
	c_sleep: cover property (s.sleep_req ##1 conv_done_i ##1 s.sleep_on);
	c_irq: cover property (s.irq && !$past(irq_o));
endmodule

/* File: test/asf_core_model.sv */
// behavioural conversion core: one result per bench fire, one after start
// assumes the flag logic clock; result line scrambles while idle
`timescale 1ns/100ps
module asf_core_model import asf_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// requests
	input wire logic fire_i,
	input wire logic [ASF_CHW-1:0] chan_i,
	input wire logic [ASF_DW-1:0] data_i,
	input wire logic start_i,
	// towards the flag logic
	output logic done_o,
	output logic [ASF_CHW-1:0] chan_o,
	output logic [ASF_DW-1:0] data_o
);
	logic [2:0] cnt;
	always @(posedge clk_i) begin
		done_o <= 1'h0;
		// inverted so a stale result is never mistaken for a new one
		data_o <= ~data_o;
		if (rst_i) begin
			cnt <= 3'h0;
			chan_o <= '0;
			data_o <= '0;
		end else begin
			if (fire_i || cnt == 3'h1) begin
				done_o <= 1'h1;
				chan_o <= fire_i ? chan_i : '0;
				data_o <= data_i;
			end
			if (start_i)
				cnt <= 3'h4;
			else if (cnt != 3'h0)
				cnt <= cnt - 3'h1;
		end
	end
endmodule

/* File: test/adc_status_flag_logic_tb_top.sv */
// bench for the status flag logic: wishbone master, queued read checks
// assumes the core model file and the flag logic package
`timescale 1ns/100ps
module adc_status_flag_logic_tb_top import asf_pkg::*;;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc_i, stb_i, we_i, fire_i, ack_o, start_o, sleep_o, irq_o, done;
	logic [7:0] adr_i, chan_en;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, r;
	logic [2:0] fch, cch;
	logic [ASF_DW-1:0] fdat, cdat;
	logic [ASF_DW-1:0] d [10];
	logic [31:0] exp_q [$];
	logic [7:0] adr_q [$];
	int seed = 60787;
	int bad_count = 0;
	int checks_done = 0;
	int k;
	always #25 clk_i = ~clk_i;
	asf_status_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o), .conv_done_i(done),
		.conv_chan_i(cch), .conv_data_i(cdat), .start_o(start_o), .sleep_o(sleep_o),
		.chan_en_o(chan_en), .irq_o(irq_o));
	asf_core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire_i), .chan_i(fch), .data_i(fdat),
		.start_i(start_o), .done_o(done), .chan_o(cch), .data_o(cdat));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		fire_i <= 1'h0;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= v;
		sel_i <= s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 20);
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		if (n >= 20) begin
			chk("bus ack", 32'h1, 32'h0);
			report_and_stop();
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		adr_q.push_back(a);
		bus(1'h0, a, 32'h0, 4'hf);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		bus(1'h1, a, v, 4'h1);
	endtask
	// the result lands on the take edge of the bus access that follows
	task fire(input logic [2:0] ch, input logic [ASF_DW-1:0] v);
		@(posedge clk_i);
		fire_i <= 1'h1;
		fch <= ch;
		fdat <= v;
	endtask
	task conv(input logic [2:0] ch, input logic [ASF_DW-1:0] v);
		fire(ch, v);
		@(posedge clk_i);
		fire_i <= 1'h0;
		repeat (2) @(posedge clk_i);
	endtask
	function logic [31:0] sr(input logic [7:0] e, input logic [7:0] o, input logic dr, input logic gv);
		sr = 32'(e) | (32'(o) << ASF_SR_CHANNEL_OVERRUN_FLAG_LSB) | (32'(dr) << ASF_SR_DATA_READY_FLAG) | (32'(gv) << ASF_SR_GENERAL_OVERRUN_FLAG);
	endfunction
	function logic [31:0] lc(input logic [2:0] ch, input logic [ASF_DW-1:0] v);
		lc = (32'(ch) << ASF_LAST_CONVERTED_DATA_REG_CH_LSB) | 32'(v);
	endfunction
	function logic [7:0] cdr(input int i);
		cdr = ASF_OFF_CDR0 + 8'(4 * i);
	endfunction
	always @(posedge clk_i) begin
		if (ack_o === 1'h1 && we_i === 1'h0) begin
			if (exp_q.size() == 0)
				chk("read queue", 32'h1, 32'h0);
			else
				chk($sformatf("read %h", adr_q.pop_front()), exp_q.pop_front(), dat_o);
		end
	end
	initial begin
		cyc_i = 1'h0;
		stb_i = 1'h0;
		we_i = 1'h0;
		fire_i = 1'h0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0;
		fch = 3'h0;
		fdat = '0;
		foreach (d[i]) begin
			r = $random(seed);
			d[i] = r[ASF_DW-1:0];
		end
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(ASF_OFF_SR, 32'h0);
		rd(ASF_OFF_CHSR, 32'h0);
		rd(ASF_OFF_IER, 32'h0);
		rd(8'h40, 32'h0);
		bus(1'h1, ASF_OFF_CHEN, 32'hff, 4'he);
		wr(ASF_OFF_CHEN, 32'h0f);
		rd(ASF_OFF_CHSR, 32'h0f);
		$display("end of test reset");
		conv(3'h1, d[0]);
		chk("irq masked", 32'h0, 32'(irq_o));
		rd(ASF_OFF_ISR, 32'h1);
		wr(ASF_OFF_IER, 32'h1);
		@(posedge clk_i);
		chk("irq", 32'h1, 32'(irq_o));
		wr(ASF_OFF_ICR, 32'h7);
		@(posedge clk_i);
		chk("irq cleared", 32'h0, 32'(irq_o));
		rd(ASF_OFF_SR, sr(8'h02, 8'h0, 1'h1, 1'h0));
		rd(cdr(1), 32'(d[0]));
		rd(ASF_OFF_SR, sr(8'h0, 8'h0, 1'h1, 1'h0));
		rd(ASF_OFF_LAST_CONVERTED_DATA_REG, lc(3'h1, d[0]));
		rd(ASF_OFF_SR, 32'h0);
		conv(3'h2, d[1]);
		fire(3'h5, d[2]);
		rd(ASF_OFF_LAST_CONVERTED_DATA_REG, lc(3'h2, d[1]));
		rd(ASF_OFF_SR, 32'h0);
		rd(cdr(5), 32'h0);
		$display("end of test ready");
		conv(3'h2, d[3]);
		fire(3'h2, d[4]);
		wr(ASF_OFF_CHDIS, 32'h08);
		rd(ASF_OFF_SR, sr(8'h04, 8'h04, 1'h1, 1'h1));
		rd(ASF_OFF_CHSR, 32'h07);
		chk("chan_en", 32'h07, 32'(chan_en));
		rd(cdr(2), 32'(d[4]));
		rd(ASF_OFF_SR, sr(8'h0, 8'h0, 1'h1, 1'h0));
		rd(ASF_OFF_LAST_CONVERTED_DATA_REG, lc(3'h2, d[4]));
		wr(ASF_OFF_CHEN, 32'h08);
		fire(3'h0, d[5]);
		wr(ASF_OFF_CHDIS, 32'h08);
		rd(ASF_OFF_SR, sr(8'h01, 8'h0, 1'h1, 1'h0));
		conv(3'h1, d[6]);
		rd(ASF_OFF_SR, sr(8'h03, 8'h0, 1'h1, 1'h1));
		fire(3'h1, d[7]);
		rd(cdr(3), 32'h0);
		rd(ASF_OFF_SR, sr(8'h03, 8'h02, 1'h1, 1'h1));
		fire(3'h3, d[2]);
		rd(cdr(0), 32'(d[5]));
		rd(ASF_OFF_SR, sr(8'h02, 8'h0, 1'h1, 1'h0));
		conv(3'h1, d[8]);
		rd(cdr(1), 32'(d[8]));
		fire(3'h1, d[9]);
		rd(ASF_OFF_SR, sr(8'h0, 8'h02, 1'h1, 1'h1));
		rd(ASF_OFF_SR, sr(8'h02, 8'h0, 1'h1, 1'h1));
		conv(3'h2, d[0]);
		rd(ASF_OFF_LAST_CONVERTED_DATA_REG, lc(3'h2, d[0]));
		fire(3'h0, d[1]);
		rd(ASF_OFF_SR, sr(8'h02, 8'h0, 1'h0, 1'h1));
		rd(ASF_OFF_SR, sr(8'h03, 8'h0, 1'h1, 1'h0));
		fire(3'h2, d[3]);
		rd(ASF_OFF_SR, sr(8'h03, 8'h0, 1'h1, 1'h0));
		rd(ASF_OFF_SR, sr(8'h07, 8'h0, 1'h1, 1'h1));
		rd(ASF_OFF_LAST_CONVERTED_DATA_REG, lc(3'h2, d[3]));
		fire(3'h1, d[2]);
		rd(cdr(3), 32'h0);
		rd(ASF_OFF_SR, sr(8'h03, 8'h02, 1'h1, 1'h0));
		rd(ASF_OFF_ISR, 32'h7);
		chk("irq level", 32'h1, 32'(irq_o));
		$display("end of test overrun");
		wr(ASF_OFF_MODE, 32'h1);
		rd(ASF_OFF_MODE, 32'h1);
		repeat (4) @(posedge clk_i);
		chk("sleep idle", 32'h0, 32'(sleep_o));
		wr(ASF_OFF_CTRL, 32'h1);
		for (k = 0; k < 20 && sleep_o !== 1'h1; k++)
			@(posedge clk_i);
		chk("sleep", 32'h1, 32'(sleep_o));
		$display("end of test sleep");
		report_and_stop();
	end
endmodule
